// ===== hdl/pulse_flasher_pkg.sv
package pulse_flasher_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_INTERVAL = 12'h004;
  localparam logic [11:0] OFF_STATUS   = 12'h008;
  localparam logic [11:0] OFF_COUNT    = 12'h00c;

  // ctrl fields
  localparam int CTRL_EN_USED_BIT  = 0;
  localparam int CTRL_RST_USED_BIT = 1;
  localparam int CTRL_UNIT_LSB     = 2;
  localparam int CTRL_UNIT_W       = 2;

  // status fields
  localparam int STAT_FLASH_BIT   = 0;
  localparam int STAT_RUNNING_BIT = 1;
  localparam int STAT_EN_BIT      = 2;
  localparam int STAT_RST_BIT     = 3;

  // ****************************************************************
  // interval value and units
  // ****************************************************************
  localparam int INTERVAL_W = 14;
  localparam int COUNT_W    = 26;

  // value is in hundredths: 1 means 0.01, 9999 means 99.99
  localparam logic [INTERVAL_W-1:0] INTERVAL_MIN   = 14'h0001;
  localparam logic [INTERVAL_W-1:0] INTERVAL_MAX   = 14'h270f;
  localparam logic [INTERVAL_W-1:0] INTERVAL_RESET = 14'h0064;

  typedef enum logic [1:0] {
    UNIT_SEC  = 2'h0,
    UNIT_MIN  = 2'h1,
    UNIT_HOUR = 2'h2
  } unit_t;

  localparam logic [1:0] UNIT_RESET = 2'h0;

  // ticks of one hundredth of the chosen unit, counted in 10 ms ticks
  localparam logic [11:0] SCALE_SEC  = 12'h001;
  localparam logic [11:0] SCALE_MIN  = 12'h03c;
  localparam logic [11:0] SCALE_HOUR = 12'he10;

  // ****************************************************************
  // time base
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_TIME_NS  = 10_000_000;
  localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } flasher_state_t;

endpackage

// ===== hdl/pulse_flasher.sv
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module pulse_flasher #(
  parameter int TICK_CYCLES = pulse_flasher_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // function block terminals
  input  wire logic        enable_in,
  input  wire logic        reset_in,
  output logic             flash_out
);

  // ****************************************************************
  // parameter checks
  // ****************************************************************
  localparam int DIV_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic                                         en_used;
  logic                                         rst_used;
  logic [1:0]                                   unit_sel;
  logic [pulse_flasher_pkg::INTERVAL_W-1:0]     interval;
  logic [pulse_flasher_pkg::COUNT_W-1:0]        term;
  logic [pulse_flasher_pkg::COUNT_W-1:0]        count;
  logic [DIV_W-1:0]                             div;
  logic                                         tick;
  pulse_flasher_pkg::flasher_state_t            state;

  logic                                         en_eff;
  logic                                         rst_eff;
  logic                                         access;
  logic                                         wr_ok;
  logic                                         addr_hit;
  logic                                         bad_write;
  logic [11:0]                                  next_scale;
  logic [pulse_flasher_pkg::COUNT_W-1:0]        next_term;
  logic [31:0]                                  next_rdata;
  logic [pulse_flasher_pkg::INTERVAL_W-1:0]     wr_interval;
  logic [1:0]                                   wr_unit;

  // ****************************************************************
  // terminal qualification
  // ****************************************************************
  // a terminal that software marks unconnected reads as low
  assign en_eff  = enable_in & en_used;
  assign rst_eff = reset_in & rst_used;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  // pready is a flop, so every access takes one wait cycle
  assign access      = psel & penable & ~pready;
  assign wr_interval = pwdata[pulse_flasher_pkg::INTERVAL_W-1:0];
  assign wr_unit     = pwdata[pulse_flasher_pkg::CTRL_UNIT_LSB +: pulse_flasher_pkg::CTRL_UNIT_W];

  always_comb begin
    addr_hit  = 1'b1;
    bad_write = 1'b0;
    case (paddr)
      pulse_flasher_pkg::OFF_CTRL: begin
        // the unused unit code is refused, not stored
        bad_write = pwrite && (wr_unit > 2'(pulse_flasher_pkg::UNIT_HOUR));
      end
      pulse_flasher_pkg::OFF_INTERVAL: begin
        bad_write = pwrite && ((wr_interval < pulse_flasher_pkg::INTERVAL_MIN)
                    || (wr_interval > pulse_flasher_pkg::INTERVAL_MAX)
                    || (pwdata[31:pulse_flasher_pkg::INTERVAL_W] != '0));
      end
      pulse_flasher_pkg::OFF_STATUS: begin
        bad_write = pwrite;
      end
      pulse_flasher_pkg::OFF_COUNT: begin
        bad_write = pwrite;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  assign wr_ok = access & pwrite & addr_hit & ~bad_write;

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      pulse_flasher_pkg::OFF_CTRL: begin
        next_rdata[pulse_flasher_pkg::CTRL_EN_USED_BIT]  = en_used;
        next_rdata[pulse_flasher_pkg::CTRL_RST_USED_BIT] = rst_used;
        next_rdata[pulse_flasher_pkg::CTRL_UNIT_LSB +: pulse_flasher_pkg::CTRL_UNIT_W] = unit_sel;
      end
      pulse_flasher_pkg::OFF_INTERVAL: begin
        next_rdata[pulse_flasher_pkg::INTERVAL_W-1:0] = interval;
      end
      pulse_flasher_pkg::OFF_STATUS: begin
        next_rdata[pulse_flasher_pkg::STAT_FLASH_BIT]   = flash_out;
        next_rdata[pulse_flasher_pkg::STAT_RUNNING_BIT] = (state == pulse_flasher_pkg::ST_RUN);
        next_rdata[pulse_flasher_pkg::STAT_EN_BIT]      = en_eff;
        next_rdata[pulse_flasher_pkg::STAT_RST_BIT]     = rst_eff;
      end
      pulse_flasher_pkg::OFF_COUNT: begin
        next_rdata[pulse_flasher_pkg::COUNT_W-1:0] = count;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // ****************************************************************
  // apb answer
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access;
      pslverr <= access & (~addr_hit | bad_write);
      if (access && !pwrite) begin
        prdata <= next_rdata;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_used  <= 1'b0;
      rst_used <= 1'b0;
      unit_sel <= pulse_flasher_pkg::UNIT_RESET;
    end else if (wr_ok && (paddr == pulse_flasher_pkg::OFF_CTRL)) begin
      en_used  <= pwdata[pulse_flasher_pkg::CTRL_EN_USED_BIT];
      rst_used <= pwdata[pulse_flasher_pkg::CTRL_RST_USED_BIT];
      unit_sel <= wr_unit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval <= pulse_flasher_pkg::INTERVAL_RESET;
    end else if (wr_ok && (paddr == pulse_flasher_pkg::OFF_INTERVAL)) begin
      interval <= wr_interval;
    end
  end

  // ****************************************************************
  // terminal count
  // ****************************************************************
  // registered so the multiplier stays off the counter's compare path
  always_comb begin
    case (unit_sel)
      pulse_flasher_pkg::UNIT_MIN: begin
        next_scale = pulse_flasher_pkg::SCALE_MIN;
      end
      pulse_flasher_pkg::UNIT_HOUR: begin
        next_scale = pulse_flasher_pkg::SCALE_HOUR;
      end
      default: begin
        next_scale = pulse_flasher_pkg::SCALE_SEC;
      end
    endcase
    next_term = pulse_flasher_pkg::COUNT_W'(interval) * pulse_flasher_pkg::COUNT_W'(next_scale);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term <= '0;
    end else begin
      term <= next_term;
    end
  end

  // ****************************************************************
  // time base
  // ****************************************************************
  // held at zero outside run so the first interval after a start is a full one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div  <= DIV_ZERO;
      tick <= 1'b0;
    end else if (state != pulse_flasher_pkg::ST_RUN) begin
      div  <= DIV_ZERO;
      tick <= 1'b0;
    end else if (div == DIV_LAST) begin
      div  <= DIV_ZERO;
      tick <= 1'b1;
    end else begin
      div  <= div + DIV_W'(1);
      tick <= 1'b0;
    end
  end

  // ****************************************************************
  // flasher sequencing
  // ****************************************************************
  // idle is left only with enable high and reset low, so both a
  // fresh enable edge and a reset release restart from output low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= pulse_flasher_pkg::ST_IDLE;
      count     <= '0;
      flash_out <= 1'b0;
    end else if (rst_eff) begin
      state     <= pulse_flasher_pkg::ST_IDLE;
      count     <= '0;
      flash_out <= 1'b0;
    end else if (!en_eff) begin
      state     <= pulse_flasher_pkg::ST_IDLE;
      count     <= '0;
      flash_out <= 1'b0;
    end else begin
      case (state)
        pulse_flasher_pkg::ST_IDLE: begin
          state     <= pulse_flasher_pkg::ST_RUN;
          count     <= '0;
          flash_out <= 1'b0;
        end
        pulse_flasher_pkg::ST_RUN: begin
          if (tick) begin
            // compare with >= so a shortened interval ends at once
            if ((count + pulse_flasher_pkg::COUNT_W'(1)) >= term) begin
              count     <= '0;
              flash_out <= ~flash_out;
            end else begin
              count <= count + pulse_flasher_pkg::COUNT_W'(1);
            end
          end
        end
        default: begin
          state     <= pulse_flasher_pkg::ST_IDLE;
          count     <= '0;
          flash_out <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ===== test/pulse_flasher_assertions.sv
`timescale 1ns/1ps
module pulse_flasher_assertions (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // terminals
  input wire logic        enable_in,
  input wire logic        reset_in,
  input wire logic        flash_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****
  // flasher
  // ****
  property p_en_low; !enable_in |=> !flash_out; endproperty
  a_en_low: assert property (p_en_low)
    else $error("flash high with enable low");
  property p_rst; reset_in |=> !flash_out; endproperty
  a_rst: assert property (p_rst)
    else $error("flash high with reset high");
  property p_start_low; $rose(enable_in) |=> !flash_out [*2]; endproperty
  a_start_low: assert property (p_start_low)
    else $error("flash not low at start");
  property p_rise_cause; $rose(flash_out) |-> $past(enable_in) && !$past(reset_in); endproperty
  a_rise_cause: assert property (p_rise_cause)
    else $error("flash rose without enable");
  property p_hold; $changed(flash_out) && enable_in && !reset_in |=> $stable(flash_out); endproperty
  a_hold: assert property (p_hold)
    else $error("flash toggled twice in a row");
  // ****
  // apb
  // ****
  property p_ready; psel && penable && !pready |=> pready; endproperty
  a_ready: assert property (p_ready)
    else $error("no ready one cycle after access");
  property p_no_ready; !(psel && penable) |=> !pready; endproperty
  a_no_ready: assert property (p_no_ready)
    else $error("ready without access");
  property p_rdata; !pready |-> prdata == 32'h0000_0000 && !pslverr; endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data or error outside ready");
endmodule

// ===== test/fb_partner.sv
`timescale 1ns/1ps
module fb_partner (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // commands
  input  wire logic en_cmd,
  input  wire logic rst_cmd,
  // terminals
  output logic      enable_in,
  output logic      reset_in
);
  // registered like a scan result, so levels only move after an edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_in <= 1'b0;
      reset_in  <= 1'b0;
    end else begin
      enable_in <= en_cmd;
      reset_in  <= rst_cmd;
    end
  end
endmodule

// ===== test/pulse_flasher_test.sv
`timescale 1ns/1ps
module pulse_flasher_test;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        en_cmd = 1'b0;
  logic        rst_cmd = 1'b0;
  logic        enable_in;
  logic        reset_in;
  logic        flash_out;
  int          errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  always #20 pclk = ~pclk;
  pulse_flasher #(.TICK_CYCLES(2)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .enable_in(enable_in), .reset_in(reset_in),
    .flash_out(flash_out));
  fb_partner far (.pclk(pclk), .presetn(presetn), .en_cmd(en_cmd), .rst_cmd(rst_cmd),
    .enable_in(enable_in), .reset_in(reset_in));
  // ****
  // helpers
  // ****
  task report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 100000) begin
      errors++;
      report_and_stop();
    end
  end
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // answer taken at the rising edge that samples pready high, then released
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp,
           input logic err);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    check("pslverr", pslverr, err);
    if (!w) check("prdata", prdata, exp);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wait_lvl(input logic v, output int n);
    n = 0;
    while (flash_out !== v && n < 30000) begin
      @(negedge pclk);
      n++;
    end
  endtask
  // ****
  // scenarios
  // ****
  task t_regs();
    apb(0, pulse_flasher_pkg::OFF_CTRL, 0, 32'h0000_0000, 0);
    apb(0, pulse_flasher_pkg::OFF_INTERVAL, 0, 32'h0000_0064, 0);
    apb(0, 12'h010, 0, 32'h0000_0000, 1);
    apb(1, pulse_flasher_pkg::OFF_STATUS, 32'h0000_0001, 0, 1);
    apb(1, pulse_flasher_pkg::OFF_CTRL, 32'h0000_000c, 0, 1);
    apb(0, pulse_flasher_pkg::OFF_CTRL, 0, 32'h0000_0000, 0);
    apb(1, pulse_flasher_pkg::OFF_INTERVAL, 32'h0000_0000, 0, 1);
    apb(1, pulse_flasher_pkg::OFF_INTERVAL, 32'h0000_2710, 0, 1);
    apb(1, pulse_flasher_pkg::OFF_INTERVAL, 32'h0000_4001, 0, 1);
    apb(1, pulse_flasher_pkg::OFF_INTERVAL, 32'h0000_270f, 0, 0);
    apb(0, pulse_flasher_pkg::OFF_INTERVAL, 0, 32'h0000_270f, 0);
    $display("test regs done");
  endtask
  task t_unassigned();
    int hi;
    hi = 0;
    en_cmd <= 1'b1;
    repeat (40) @(negedge pclk) if (flash_out !== 1'b0) hi++;
    check("flash unassigned", hi, 0);
    @(posedge pclk);
    en_cmd <= 1'b0;
    $display("test unassigned done");
  endtask
  task t_blink(input logic [1:0] u, input logic [13:0] iv, input int half);
    int n;
    apb(1, pulse_flasher_pkg::OFF_INTERVAL, {18'h0_0000, iv}, 0, 0);
    apb(1, pulse_flasher_pkg::OFF_CTRL, {28'h000_0000, u, 2'h3}, 0, 0);
    @(posedge pclk);
    en_cmd <= 1'b1;
    wait_lvl(1, n);
    check("first low long", n >= half, 1);
    wait_lvl(0, n);
    check("on time", n, half);
    wait_lvl(1, n);
    check("off time", n, half);
    @(posedge pclk);
    en_cmd <= 1'b0;
    repeat (3) @(negedge pclk);
    check("flash after stop", flash_out, 0);
    $display("test blink done");
  endtask
  task t_reset();
    int n;
    wait_lvl(1, n);
    @(posedge pclk);
    rst_cmd <= 1'b1;
    repeat (3) @(negedge pclk);
    check("flash in reset", flash_out, 0);
    repeat (10) @(negedge pclk);
    check("flash held in reset", flash_out, 0);
    apb(0, pulse_flasher_pkg::OFF_STATUS, 0, 32'h0000_000c, 0);
    apb(0, pulse_flasher_pkg::OFF_COUNT, 0, 32'h0000_0000, 0);
    rst_cmd <= 1'b0;
    wait_lvl(1, n);
    check("low after release", n >= 2, 1);
    wait_lvl(0, n);
    check("on after release", n, 2);
    en_cmd <= 1'b0;
    $display("test reset done");
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_unassigned();
    t_blink(2'h0, 14'h0002, 4);
    t_blink(2'h1, 14'h0001, 120);
    t_blink(2'h2, 14'h0001, 7200);
    t_blink(2'h0, 14'h0001, 2);
    en_cmd <= 1'b1;
    t_reset();
    report_and_stop();
  end
endmodule
bind pulse_flasher pulse_flasher_assertions chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .enable_in(enable_in), .reset_in(reset_in), .flash_out(flash_out));
